// ==== rrss_pkg.sv ====
// Purpose: Shared constants and types for the return, rotate, subtract and halt executor.
// Assumes: One instruction clock; the caller decodes opcodes into rrss_op_t.
// Notes:   Reset values of the status flags follow the power-on state.
package rrss_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DATA_W      = 8;
	localparam int PC_W        = 15;
	localparam int STACK_DEPTH = 16;
	localparam int WDT_W       = 8;
	localparam int PRESC_W     = 8;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int MSB_POS       = 7;
	localparam int LSB_POS       = 0;
	localparam int NIB_MSB       = 3;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam logic RST_CARRY   = 1'b0;
	localparam logic RST_HALF    = 1'b0;
	localparam logic RST_ZERO    = 1'b0;
	localparam logic RST_TIMEOUT = 1'b1;
	localparam logic RST_PDOWN   = 1'b1;
	localparam logic HALT_TIMEOUT = 1'b1;
	localparam logic HALT_PDOWN   = 1'b0;
	localparam logic DEST_ACC    = 1'b0;
	localparam logic DEST_FILE   = 1'b1;

	// ------------------------------------------------------------
	// Timing: returns take two instruction cycles
	// ------------------------------------------------------------
	localparam int RET_CYCLES = 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE   = 3'h0,
		OP_RETURN = 3'h1,
		OP_RETLIT = 3'h2,
		OP_ROTL   = 3'h3,
		OP_ROTR   = 3'h4,
		OP_SUBLIT = 3'h5,
		OP_HALT   = 3'h6
	} rrss_op_t;

	// Gray codes along idle -> second return cycle, idle -> halted
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RET2 = 2'b01,
		ST_HALT = 2'b10
	} rrss_state_t;

endpackage

// ==== rrss_stack.sv ====
// Purpose: Hardware return stack holding return addresses.
// Assumes: Push and pop never requested in the same cycle by the core.
// Notes:   Overflow wraps the pointer; underflow wraps it too and reads slot DEPTH-1.
`timescale 1ns/100ps
module rrss_stack #(
	parameter int DEPTH = rrss_pkg::STACK_DEPTH,
	parameter int ADDR_W = rrss_pkg::PC_W
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Requests
	input  wire logic              push,
	input  wire logic [ADDR_W-1:0] pushAddr,
	input  wire logic              pop,
	// State
	output logic      [ADDR_W-1:0] stackTop,
	output logic [$clog2(DEPTH)-1:0] stackPtr
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	logic [ADDR_W-1:0] slot [DEPTH];
	logic [PTR_W-1:0]  topIdx;

	// Pointer names the next free slot; top is the slot below it
	assign topIdx   = stackPtr - PTR_ONE;
	assign stackTop = slot[topIdx];

	// ------------------------------------------------------------
	// Pointer
	// ------------------------------------------------------------
	// Each pop steps back one entry, exposing the next older address
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			stackPtr <= '0;
		else if (pop)
			stackPtr <= stackPtr - PTR_ONE;
		else if (push)
			stackPtr <= stackPtr + PTR_ONE;
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Slots are not reset; software never returns before a call
	always_ff @(posedge sys_clk)
	begin
		if (push && !pop)
			slot[stackPtr] <= pushAddr;
	end

endmodule

// ==== rrss_core.sv ====
// Purpose: Executes returns, rotates through carry, literal subtract and halt.
// Assumes: Operands arrive with opValid; the file register value is on srcData.
// Notes:   Watchdog and its prescaler live here so halt can clear them.
//
// Contract
// - Plain return pops stack into program counter, two cycles, flags untouched.
// - Literal return writes the 8-bit literal into accumulator, flags untouched.
// - Literal return also pops stack into program counter in two cycles.
// - Rotate left: old carry into bit 0, old bit 7 into carry.
// - Rotate right: old carry into bit 7, old bit 0 into carry.
// - Select zero writes accumulator; select one writes back the file register.
// - Literal subtract stores literal minus accumulator in the accumulator.
// - Carry, half carry by compare; zero flag marks a zero result.
// - Halt sets timeout flag and clears powerdown flag, arithmetic flags untouched.
// - Halt clears the watchdog counter and its prescaler.
// - Halt stops execution and the oscillator until woken.
`timescale 1ns/100ps
module rrss_core #(
	parameter int DATA_W  = rrss_pkg::DATA_W,
	parameter int PC_W    = rrss_pkg::PC_W,
	parameter int DEPTH   = rrss_pkg::STACK_DEPTH,
	parameter int WDT_W   = rrss_pkg::WDT_W,
	parameter int PRESC_W = rrss_pkg::PRESC_W
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	// Instruction issue
	input  wire logic                     opValid,
	input  wire rrss_pkg::rrss_op_t       opCode,
	input  wire logic [DATA_W-1:0]        literal,
	input  wire logic                     destSel,
	input  wire logic [DATA_W-1:0]        srcData,
	output logic                          opReady,
	// Call side of the return stack
	input  wire logic                     callPush,
	input  wire logic [PC_W-1:0]          callAddr,
	// Wake pin, asynchronous
	input  wire logic                     wakePin,
	// File register write-back
	output logic                          fileWrite,
	output logic [DATA_W-1:0]             fileData,
	// Architectural state
	output logic [DATA_W-1:0]             accumulator,
	output logic [PC_W-1:0]               programCounter,
	output logic                          carryFlag,
	output logic                          halfCarryFlag,
	output logic                          zeroFlag,
	output logic                          timeoutFlag,
	output logic                          powerdownFlag,
	output logic [WDT_W-1:0]              watchdogCounter,
	output logic [PRESC_W-1:0]            watchdogPrescaler,
	output logic                          oscRun,
	output logic [$clog2(DEPTH)-1:0]      stackPtr
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	localparam logic [PC_W-1:0]    PC_ONE    = PC_W'(1);
	localparam logic [WDT_W-1:0]   WDT_ONE   = WDT_W'(1);
	localparam logic [PRESC_W-1:0] PRESC_ONE = PRESC_W'(1);
	localparam logic [PRESC_W-1:0] PRESC_MAX = '1;

	// No-borrow test used for both the byte and the nibble compare
	function automatic logic noBorrow(input logic [DATA_W-1:0] minuend,
		input logic [DATA_W-1:0] subtrahend);
		noBorrow = (subtrahend <= minuend);
	endfunction

	rrss_pkg::rrss_state_t state;
	rrss_pkg::rrss_state_t next_state;
	logic                  take;
	logic                  isReturn;
	logic                  stackPop;
	logic [PC_W-1:0]       stackTop;
	logic                  wakeMeta;
	logic                  wakeSync;
	logic [DATA_W-1:0]     rotLeft;
	logic [DATA_W-1:0]     rotRight;
	logic [DATA_W-1:0]     rotResult;
	logic                  rotCarry;
	logic [DATA_W-1:0]     subResult;
	logic [DATA_W-1:0]     litLowNib;
	logic [DATA_W-1:0]     accLowNib;

	// ------------------------------------------------------------
	// Issue and decode
	// ------------------------------------------------------------
	// New work only in the idle state; halt and second return cycle stall
	assign opReady  = (state == rrss_pkg::ST_IDLE);
	assign take     = opValid && opReady;
	assign isReturn = (opCode == rrss_pkg::OP_RETURN) || (opCode == rrss_pkg::OP_RETLIT);
	assign stackPop = take && isReturn;

	rrss_stack #(
		.DEPTH  (DEPTH),
		.ADDR_W (PC_W)
	) u_stack (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.push     (callPush && !stackPop),
		.pushAddr (callAddr),
		.pop      (stackPop),
		.stackTop (stackTop),
		.stackPtr (stackPtr)
	);

	// Wake pin synchroniser; only the second stage is read
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wakeMeta <= 1'b0;
			wakeSync <= 1'b0;
		end
		else
		begin
			wakeMeta <= wakePin;
			wakeSync <= wakeMeta;
		end
	end

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	// Rotations go through carry; subtract is plain two's complement
	always_comb
	begin
		rotLeft   = {srcData[rrss_pkg::MSB_POS-1:rrss_pkg::LSB_POS], carryFlag};
		rotRight  = {carryFlag, srcData[rrss_pkg::MSB_POS:rrss_pkg::LSB_POS+1]};
		rotResult = (opCode == rrss_pkg::OP_ROTL) ? rotLeft : rotRight;
		rotCarry  = (opCode == rrss_pkg::OP_ROTL) ? srcData[rrss_pkg::MSB_POS]
		                                          : srcData[rrss_pkg::LSB_POS];
		subResult = literal - accumulator;
		litLowNib = {4'h0, literal[rrss_pkg::NIB_MSB:0]};
		accLowNib = {4'h0, accumulator[rrss_pkg::NIB_MSB:0]};
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Returns spend a second cycle; halt holds until the wake pin rises
	always_comb
	begin
		next_state = state;
		unique case (state)
			rrss_pkg::ST_IDLE:
			begin
				if (take && isReturn)
					next_state = rrss_pkg::ST_RET2;
				else if (take && opCode == rrss_pkg::OP_HALT)
					next_state = rrss_pkg::ST_HALT;
			end
			rrss_pkg::ST_RET2:
				next_state = rrss_pkg::ST_IDLE;
			rrss_pkg::ST_HALT:
			begin
				if (wakeSync)
					next_state = rrss_pkg::ST_IDLE;
			end
			default:
				next_state = rrss_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state <= rrss_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Oscillator request drops while halted
	assign oscRun = (state != rrss_pkg::ST_HALT);

	// ------------------------------------------------------------
	// Program counter
	// ------------------------------------------------------------
	// Returns load the popped address; other ops step by one word
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			programCounter <= '0;
		else if (stackPop)
			programCounter <= stackTop;
		else if (take)
			programCounter <= programCounter + PC_ONE;
	end

	// ------------------------------------------------------------
	// Accumulator and file write-back
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			accumulator <= rrss_pkg::DATA_ZERO;
		else if (take)
		begin
			unique case (opCode)
				rrss_pkg::OP_RETLIT:
					accumulator <= literal;
				rrss_pkg::OP_ROTL, rrss_pkg::OP_ROTR:
				begin
					if (destSel == rrss_pkg::DEST_ACC)
						accumulator <= rotResult;
				end
				rrss_pkg::OP_SUBLIT:
					accumulator <= subResult;
				default:
					accumulator <= accumulator;
			endcase
		end
	end

	// Write-back strobe is one cycle, registered with its data
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			fileWrite <= 1'b0;
			fileData  <= rrss_pkg::DATA_ZERO;
		end
		else
		begin
			fileWrite <= take && destSel == rrss_pkg::DEST_FILE &&
				(opCode == rrss_pkg::OP_ROTL || opCode == rrss_pkg::OP_ROTR);
			if (take)
				fileData <= rotResult;
		end
	end

	// ------------------------------------------------------------
	// Arithmetic flags
	// ------------------------------------------------------------
	// Only rotates and the literal subtract touch these
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			carryFlag     <= rrss_pkg::RST_CARRY;
			halfCarryFlag <= rrss_pkg::RST_HALF;
			zeroFlag      <= rrss_pkg::RST_ZERO;
		end
		else if (take && (opCode == rrss_pkg::OP_ROTL || opCode == rrss_pkg::OP_ROTR))
			carryFlag <= rotCarry;
		else if (take && opCode == rrss_pkg::OP_SUBLIT)
		begin
			carryFlag     <= noBorrow(literal, accumulator);
			halfCarryFlag <= noBorrow(litLowNib, accLowNib);
			zeroFlag      <= (subResult == rrss_pkg::DATA_ZERO);
		end
	end

	// ------------------------------------------------------------
	// Power status flags
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			timeoutFlag   <= rrss_pkg::RST_TIMEOUT;
			powerdownFlag <= rrss_pkg::RST_PDOWN;
		end
		else if (take && opCode == rrss_pkg::OP_HALT)
		begin
			timeoutFlag   <= rrss_pkg::HALT_TIMEOUT;
			powerdownFlag <= rrss_pkg::HALT_PDOWN;
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	// Keeps counting while halted; halt restarts both stages from zero
	always_ff @(posedge sys_clk)
	begin
		if (rst || (take && opCode == rrss_pkg::OP_HALT))
		begin
			watchdogPrescaler <= '0;
			watchdogCounter   <= '0;
		end
		else
		begin
			watchdogPrescaler <= watchdogPrescaler + PRESC_ONE;
			if (watchdogPrescaler == PRESC_MAX)
				watchdogCounter <= watchdogCounter + WDT_ONE;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	ret_pc_load_a: assert property (stackPop |=> programCounter == $past(stackTop))
		else $error("Return did not load the popped address");
	ret_two_cyc_a: assert property (stackPop |=> !opReady ##1 opReady)
		else $error("Return did not last two cycles");
	ret_flags_a: assert property (stackPop |=> $stable(carryFlag) && $stable(zeroFlag)
		&& $stable(halfCarryFlag))
		else $error("Return changed a status flag");
	retlit_acc_a: assert property (take && opCode == rrss_pkg::OP_RETLIT
		|=> accumulator == $past(literal))
		else $error("Literal return left accumulator wrong");
	rotl_value_a: assert property (take && opCode == rrss_pkg::OP_ROTL && !destSel
		|=> accumulator == {$past(srcData[6:0]), $past(carryFlag)}
		&& carryFlag == $past(srcData[7]))
		else $error("Left rotate result wrong");
	rotr_value_a: assert property (take && opCode == rrss_pkg::OP_ROTR && destSel
		|=> fileWrite && fileData == {$past(carryFlag), $past(srcData[7:1])}
		&& carryFlag == $past(srcData[0]) && $stable(accumulator))
		else $error("Right rotate write-back wrong");
	// Result, carry and half carry checked from the operands one cycle back; zero flag from the new result
	sub_flags_a: assert property (take && opCode == rrss_pkg::OP_SUBLIT
		|=> accumulator == DATA_W'($past(literal) - $past(accumulator))
		&& carryFlag == ($past(accumulator) <= $past(literal))
		&& halfCarryFlag == ($past(accumulator[3:0]) <= $past(literal[3:0]))
		&& zeroFlag == (accumulator == 8'h00))
		else $error("Subtract result or flags wrong");
	halt_flags_a: assert property (take && opCode == rrss_pkg::OP_HALT
		|=> timeoutFlag && !powerdownFlag && watchdogCounter == 8'h00
		&& watchdogPrescaler == 8'h00 && !oscRun)
		else $error("Halt did not set status and clear watchdog");
	halt_hold_a: assert property (!oscRun && !wakeSync |=> !oscRun && !opReady)
		else $error("Left halt without a wake");
	pop_ptr_a: assert property (stackPop |=> stackPtr == $past(stackPtr) - 4'h1)
		else $error("Pop did not step the stack pointer back");

endmodule

// ==== return_rotate_subtract_sleep_ops_tb.sv ====
// Purpose: Self-checking bench for the return, rotate, subtract and halt executor.
// Assumes: Inputs change on the falling edge; results are checked on the falling edge half a cycle after the taking edge.
// Notes:   Table rows chain flag state, so row order matters.
`timescale 1ns/100ps
module return_rotate_subtract_sleep_ops_tb;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct {
		rrss_pkg::rrss_op_t op;
		logic [7:0]         lit;
		logic               dsel;
		logic [7:0]         src;
		logic [7:0]         acc;
		logic [2:0]         czd;
		logic               fw;
		logic [7:0]         fd;
	} rrss_row_t;

	localparam int LIMIT = 2000;
	logic               sysClk = 1'b0; // Low from the start: no false edge at time zero
	logic               rst;
	logic               opValid;
	rrss_pkg::rrss_op_t opCode;
	logic [7:0]         literal;
	logic               destSel;
	logic [7:0]         srcData;
	logic               opReady;
	logic               callPush;
	logic [14:0]        callAddr;
	logic               wakePin;
	logic               fileWrite;
	logic [7:0]         fileData;
	logic [7:0]         accumulator;
	logic [14:0]        programCounter;
	logic               carryFlag;
	logic               halfCarryFlag;
	logic               zeroFlag;
	logic               timeoutFlag;
	logic               powerdownFlag;
	logic [7:0]         watchdogCounter;
	logic [7:0]         watchdogPrescaler;
	logic               oscRun;
	logic [3:0]         stackPtr;
	logic [2:0]         flags;
	int                 badCount;
	int                 checksDone;
	int                 cycles;
	int                 k;
	rrss_row_t          rows [10];

	assign flags = {carryFlag, halfCarryFlag, zeroFlag};

	rrss_core rrss_core_i (
		.sys_clk           (sysClk),
		.rst               (rst),
		.opValid           (opValid),
		.opCode            (opCode),
		.literal           (literal),
		.destSel           (destSel),
		.srcData           (srcData),
		.opReady           (opReady),
		.callPush          (callPush),
		.callAddr          (callAddr),
		.wakePin           (wakePin),
		.fileWrite         (fileWrite),
		.fileData          (fileData),
		.accumulator       (accumulator),
		.programCounter    (programCounter),
		.carryFlag         (carryFlag),
		.halfCarryFlag     (halfCarryFlag),
		.zeroFlag          (zeroFlag),
		.timeoutFlag       (timeoutFlag),
		.powerdownFlag     (powerdownFlag),
		.watchdogCounter   (watchdogCounter),
		.watchdogPrescaler (watchdogPrescaler),
		.oscRun            (oscRun),
		.stackPtr          (stackPtr)
	);

	// ------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ------------------------------------------------------------
	// 200 MHz clock
	initial
	begin
		sysClk = 1'b0;
		forever #2.5 sysClk = ~sysClk;
	end

	// A hang counts as a mismatch rather than a silent stall
	always @(posedge sysClk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			badCount++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			badCount++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_reset();
		check("accumulator", accumulator, 32'h0000_0000);
		check("programCounter", programCounter, 32'h0000_0000);
		check("flags", flags, 32'h0000_0000);
		check("timeoutFlag", timeoutFlag, 32'h0000_0001);
		check("powerdownFlag", powerdownFlag, 32'h0000_0001);
		check("watchdogCounter", watchdogCounter, 32'h0000_0000);
		check("watchdogPrescaler", watchdogPrescaler, 32'h0000_0000);
		check("stackPtr", stackPtr, 32'h0000_0000);
		check("fileWrite", fileWrite, 32'h0000_0000);
		check("opReady", opReady, 32'h0000_0001);
		check("oscRun", oscRun, 32'h0000_0001);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	// Rows: op, literal, dest, source, acc, {C,DC,Z}, write, write data
	initial
	begin
		rows[0] = '{rrss_pkg::OP_SUBLIT, 8'h00, 1'b0, 8'h00, 8'h00, 3'b111, 1'b0, 8'h00};
		rows[1] = '{rrss_pkg::OP_ROTL, 8'h00, 1'b0, 8'hE6, 8'hCD, 3'b111, 1'b0, 8'h00};
		rows[2] = '{rrss_pkg::OP_ROTR, 8'h00, 1'b1, 8'h01, 8'hCD, 3'b111, 1'b1, 8'h80};
		rows[3] = '{rrss_pkg::OP_ROTL, 8'h00, 1'b1, 8'h66, 8'hCD, 3'b011, 1'b1, 8'hCD};
		rows[4] = '{rrss_pkg::OP_ROTR, 8'h00, 1'b0, 8'h02, 8'h01, 3'b011, 1'b0, 8'h00};
		rows[5] = '{rrss_pkg::OP_SUBLIT, 8'h10, 1'b0, 8'h00, 8'h0F, 3'b100, 1'b0, 8'h00};
		rows[6] = '{rrss_pkg::OP_SUBLIT, 8'h05, 1'b0, 8'h00, 8'hF6, 3'b000, 1'b0, 8'h00};
		rows[7] = '{rrss_pkg::OP_SUBLIT, 8'hF6, 1'b0, 8'h00, 8'h00, 3'b111, 1'b0, 8'h00};
		rows[8] = '{rrss_pkg::OP_ROTR, 8'h00, 1'b0, 8'h00, 8'h80, 3'b011, 1'b0, 8'h00};
		rows[9] = '{rrss_pkg::OP_SUBLIT, 8'hFF, 1'b0, 8'h00, 8'h7F, 3'b110, 1'b0, 8'h00};
		badCount = 0;
		checksDone = 0;
		cycles = 0;
		rst = 1'b1;
		opValid = 1'b0;
		opCode = rrss_pkg::OP_NONE;
		literal = 8'h00;
		destSel = 1'b0;
		srcData = 8'h00;
		callPush = 1'b0;
		callAddr = 15'h0000;
		wakePin = 1'b0;
		repeat (8) @(negedge sysClk);
		check_reset();
		rst = 1'b0;
		$display("test reset done");
		// Single-cycle ops issued back to back
		opValid = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			opCode = rows[i].op;
			literal = rows[i].lit;
			destSel = rows[i].dsel;
			srcData = rows[i].src;
			@(negedge sysClk);
			check("accumulator", accumulator, rows[i].acc);
			check("flags", flags, rows[i].czd);
			check("fileWrite", fileWrite, rows[i].fw);
			if (rows[i].fw)
				check("fileData", fileData, rows[i].fd);
		end
		opValid = 1'b0;
		check("programCounter", programCounter, 32'h0000_000A);
		$display("test table done");
		// Two pushes, then a return and a literal return offered in the dead cycle
		callPush = 1'b1;
		callAddr = 15'h1234;
		@(negedge sysClk);
		callAddr = 15'h0456;
		@(negedge sysClk);
		callPush = 1'b0;
		check("stackPtr", stackPtr, 32'h0000_0002);
		opValid = 1'b1;
		opCode = rrss_pkg::OP_RETURN;
		@(negedge sysClk);
		check("programCounter", programCounter, 32'h0000_0456);
		check("stackPtr", stackPtr, 32'h0000_0001);
		check("opReady", opReady, 32'h0000_0000);
		check("flags", flags, 32'h0000_0006);
		opCode = rrss_pkg::OP_RETLIT;
		literal = 8'hA5;
		@(negedge sysClk);
		check("opReady", opReady, 32'h0000_0001);
		check("programCounter", programCounter, 32'h0000_0456);
		check("accumulator", accumulator, 32'h0000_007F);
		@(negedge sysClk);
		opValid = 1'b0;
		check("programCounter", programCounter, 32'h0000_1234);
		check("accumulator", accumulator, 32'h0000_00A5);
		check("stackPtr", stackPtr, 32'h0000_0000);
		check("flags", flags, 32'h0000_0006);
		check("opReady", opReady, 32'h0000_0000);
		@(negedge sysClk);
		check("opReady", opReady, 32'h0000_0001);
		$display("test returns done");
		// Let the watchdog advance before halting
		repeat (300) @(negedge sysClk);
		opValid = 1'b1;
		opCode = rrss_pkg::OP_HALT;
		@(negedge sysClk);
		opCode = rrss_pkg::OP_SUBLIT;
		literal = 8'h00;
		check("oscRun", oscRun, 32'h0000_0000);
		check("opReady", opReady, 32'h0000_0000);
		check("timeoutFlag", timeoutFlag, 32'h0000_0001);
		check("powerdownFlag", powerdownFlag, 32'h0000_0000);
		check("flags", flags, 32'h0000_0006);
		check("watchdogCounter", watchdogCounter, 32'h0000_0000);
		check("watchdogPrescaler", watchdogPrescaler, 32'h0000_0000);
		repeat (5) @(negedge sysClk);
		check("accumulator", accumulator, 32'h0000_00A5);
		check("oscRun", oscRun, 32'h0000_0000);
		opValid = 1'b0;
		wakePin = 1'b1;
		for (k = 0; k < 10 && opReady !== 1'b1; k++)
			@(negedge sysClk);
		wakePin = 1'b0;
		check("oscRun", oscRun, 32'h0000_0001);
		check("powerdownFlag", powerdownFlag, 32'h0000_0000);
		$display("test halt done");
		// Reset again in mid-run
		rst = 1'b1;
		@(negedge sysClk);
		check_reset();
		rst = 1'b0;
		$display("test second reset done");
		final_report();
	end

endmodule
